// File: verilog/line_enable_pkg.sv
package line_enable_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] RX_LOW_OFFSET = 8'h08;
  localparam logic [7:0] TX_HIGH_OFFSET = 8'h80;
  localparam logic [7:0] RX_HIGH_OFFSET = 8'h88;
  localparam int FIELD_W = 6;
  localparam logic [5:0] RX_LOW_RESET = 6'h00;
  localparam logic [5:0] TX_HIGH_RESET = 6'h00;
  localparam logic [5:0] RX_HIGH_RESET = 6'h00;
  localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
endpackage : line_enable_pkg

// File: verilog/line_enable_regs.sv
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module line_enable_regs
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [line_enable_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic master_tx_enable_pin,
  output logic [11:0] receive_section_on,
  output logic [5:0] transmit_section_on_ch6_11,
  output logic [5:0] tx_line_oe
);
  import line_enable_pkg::*;

  typedef struct packed {
    logic [5:0] rx_low;
    logic [5:0] tx_high;
    logic [5:0] rx_high;
    logic [31:0] rdata;
    logic done;
    logic pin_meta;
    logic pin_sync;
  } state_s;

  state_s cur;
  state_s next_cur;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] pad_field(input logic [5:0] f);
    pad_field = {26'h0, f};
  endfunction : pad_field

  // One-hot select, so write and read paths cannot disagree
  function automatic logic [2:0] decode_hit(input logic [ADDR_W-1:0] a);
    decode_hit = 3'h0;
    case (a)
      RX_LOW_OFFSET: decode_hit = 3'h1;
      TX_HIGH_OFFSET: decode_hit = 3'h2;
      RX_HIGH_OFFSET: decode_hit = 3'h4;
      default: decode_hit = 3'h0;
    endcase
  endfunction : decode_hit

  logic [2:0] addr_hit;
  assign addr_hit = decode_hit(avs_address);

  always_comb
  begin
    next_cur = cur;
    next_cur.pin_meta = master_tx_enable_pin;
    next_cur.pin_sync = cur.pin_meta;
    next_cur.done = 1'b0;
    // One wait state: waitrequest drops the cycle after a request lands
    if ((avs_read || avs_write) && !cur.done)
    begin
      next_cur.done = 1'b1;
      next_cur.rdata = UNMAPPED_READ;
      // Lane 0 only: the whole field fits in the low byte
      if (avs_write && avs_byteenable[0])
      begin
        if (addr_hit[0])
          next_cur.rx_low = avs_writedata[FIELD_W-1:0];
        if (addr_hit[1])
          next_cur.tx_high = avs_writedata[FIELD_W-1:0];
        if (addr_hit[2])
          next_cur.rx_high = avs_writedata[FIELD_W-1:0];
      end
      // Unmapped reads keep the zero word set above
      if (avs_read)
      begin
        if (addr_hit[0])
          next_cur.rdata = pad_field(cur.rx_low);
        if (addr_hit[1])
          next_cur.rdata = pad_field(cur.tx_high);
        if (addr_hit[2])
          next_cur.rdata = pad_field(cur.rx_high);
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cur <= '0;
      cur.rx_low <= RX_LOW_RESET;
      cur.tx_high <= TX_HIGH_RESET;
      cur.rx_high <= RX_HIGH_RESET;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign avs_waitrequest = (avs_read || avs_write) && !cur.done;
  assign avs_readdata = cur.rdata;
  // Receiver off means the line inputs float; enable goes to the pad
  assign receive_section_on = {cur.rx_high, cur.rx_low};
  assign transmit_section_on_ch6_11 = cur.tx_high;
  // Pin is synchronised, so drivers follow it two cycles late
  assign tx_line_oe = cur.tx_high & {6{cur.pin_sync}};

  ////////////////////////////////////////////////////////////////////////////
  logic req_any;
  logic wr_done;
  logic rd_done;
  logic unmapped;
  assign req_any = avs_read || avs_write;
  assign wr_done = avs_write && !avs_waitrequest;
  assign rd_done = avs_read && !avs_waitrequest;
  assign unmapped = avs_address != RX_LOW_OFFSET
    && avs_address != TX_HIGH_OFFSET && avs_address != RX_HIGH_OFFSET;

  rx_write_a: assert property (
    @(posedge core_clk) disable iff (rst)
    wr_done && avs_address == RX_LOW_OFFSET && avs_byteenable[0]
    |=> cur.rx_low == $past(avs_writedata[FIELD_W-1:0]))
    else $error("receive low write lost");
  tx_write_a: assert property (
    @(posedge core_clk) disable iff (rst)
    wr_done && avs_address == TX_HIGH_OFFSET && avs_byteenable[0]
    |=> cur.tx_high == $past(avs_writedata[FIELD_W-1:0]))
    else $error("transmit write lost");
  rxh_write_a: assert property (
    @(posedge core_clk) disable iff (rst)
    wr_done && avs_address == RX_HIGH_OFFSET && avs_byteenable[0]
    |=> cur.rx_high == $past(avs_writedata[FIELD_W-1:0]))
    else $error("receive high write lost");

  // Pad enables judged from the bus, not from internal state
  rx_map_a: assert property (
    @(posedge core_clk) disable iff (rst)
    wr_done && avs_address == RX_LOW_OFFSET && avs_byteenable[0]
    |=> receive_section_on[5:0] == $past(avs_writedata[FIELD_W-1:0]))
    else $error("receive enable mismatch");
  rxh_map_a: assert property (
    @(posedge core_clk) disable iff (rst)
    wr_done && avs_address == RX_HIGH_OFFSET && avs_byteenable[0]
    |=> receive_section_on[11:6] == $past(avs_writedata[FIELD_W-1:0]))
    else $error("upper receive enable mismatch");
  tx_map_a: assert property (
    @(posedge core_clk) disable iff (rst)
    wr_done && avs_address == TX_HIGH_OFFSET && avs_byteenable[0]
    |=> transmit_section_on_ch6_11 == $past(avs_writedata[FIELD_W-1:0]))
    else $error("transmit enable mismatch");

  tx_pin_a: assert property (
    @(posedge core_clk) disable iff (rst)
    !$past(master_tx_enable_pin, 2) |-> tx_line_oe == 6'h00)
    else $error("driver on with pin low");
  tx_on_a: assert property (
    @(posedge core_clk) disable iff (rst)
    $past(master_tx_enable_pin, 2)
    |-> tx_line_oe == transmit_section_on_ch6_11)
    else $error("driver not following its bit");
  tx_off_a: assert property (
    @(posedge core_clk) disable iff (rst)
    wr_done && avs_address == TX_HIGH_OFFSET && avs_byteenable[0]
    |=> (tx_line_oe & ~$past(avs_writedata[FIELD_W-1:0])) == 6'h00)
    else $error("driver on with bit clear");

  reserved_zero_a: assert property (
    @(posedge core_clk) disable iff (rst)
    rd_done |-> avs_readdata[31:6] == 26'h0)
    else $error("reserved bits not zero");
  rx_read_a: assert property (
    @(posedge core_clk) disable iff (rst)
    rd_done && avs_address == RX_LOW_OFFSET
    |-> avs_readdata == {26'h0, receive_section_on[5:0]})
    else $error("receive low read wrong");
  tx_read_a: assert property (
    @(posedge core_clk) disable iff (rst)
    rd_done && avs_address == TX_HIGH_OFFSET
    |-> avs_readdata == {26'h0, transmit_section_on_ch6_11})
    else $error("transmit read wrong");
  rxh_read_a: assert property (
    @(posedge core_clk) disable iff (rst)
    rd_done && avs_address == RX_HIGH_OFFSET
    |-> avs_readdata == {26'h0, receive_section_on[11:6]})
    else $error("receive high read wrong");

  // Refused reads return zero; refused writes leave receive_section_on and transmit_section_on_ch6_11 alone
  unmapped_read_a: assert property (
    @(posedge core_clk) disable iff (rst)
    rd_done && unmapped |-> avs_readdata == UNMAPPED_READ)
    else $error("unmapped read not zero");
  unmapped_write_a: assert property (
    @(posedge core_clk) disable iff (rst)
    wr_done && unmapped
    |-> $stable(receive_section_on) && $stable(transmit_section_on_ch6_11))
    else $error("unmapped write changed an enable");
  byte_lane_a: assert property (
    @(posedge core_clk) disable iff (rst)
    wr_done && !avs_byteenable[0]
    |-> $stable(receive_section_on) && $stable(transmit_section_on_ch6_11))
    else $error("masked write changed an enable");

  read_hold_a: assert property (
    @(posedge core_clk) disable iff (rst)
    !req_any |=> $stable(avs_readdata))
    else $error("read data moved while idle");
  idle_wait_a: assert property (
    @(posedge core_clk) disable iff (rst)
    !req_any |-> !avs_waitrequest)
    else $error("waitrequest high while idle");
  first_wait_a: assert property (
    @(posedge core_clk) disable iff (rst)
    req_any && !$past(req_any) |-> avs_waitrequest)
    else $error("no wait state on new request");
  wait_one_a: assert property (
    @(posedge core_clk) disable iff (rst)
    avs_read && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest too long");
  wait_write_a: assert property (
    @(posedge core_clk) disable iff (rst)
    avs_write && avs_waitrequest |=> !avs_waitrequest)
    else $error("write waitrequest too long");
endmodule : line_enable_regs

// File: bench/line_enable_regs_tb.sv
`timescale 1ns/1ns
`define CHK(n, e, s) chk(n, e, s)
module line_enable_regs_tb;
  import line_enable_pkg::*;
  logic core_clk = 0;
  logic rst = 1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 0;
  logic avs_write = 0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest;
  logic pin = 0;
  logic [3:0] lanes = 4'hF;
  logic [11:0] rx_on;
  logic [5:0] tx_on, tx_oe;
  int n_errors = 0;
  int n_compared = 0;
  always #5 core_clk = ~core_clk;
  line_enable_regs u_line_enable_regs (.core_clk(core_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(lanes),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .master_tx_enable_pin(pin), .receive_section_on(rx_on),
    .transmit_section_on_ch6_11(tx_on), .tx_line_oe(tx_oe));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    n_compared++;
    if (s !== e)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Sampled at the rising edge, before that edge's updates land
  task automatic acc(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
  endtask : acc
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done
  initial
  begin
    repeat (2000) @(posedge core_clk);
    n_errors++;
    test_done();
  end
  initial
  begin
    repeat (6) @(posedge core_clk);
    rst <= 0;
    acc(0, TX_HIGH_OFFSET, 0);
    `CHK("reset", 32'h0, rd);
    `CHK("rx_on_reset", 32'h0, rx_on);
    `CHK("oe_reset", 32'h0, tx_oe);
    $display("test reset done");
    acc(1, RX_LOW_OFFSET, 32'hFFFFFFE5);
    acc(0, RX_LOW_OFFSET, 0);
    `CHK("rx_low", 32'h25, rd);
    acc(1, RX_HIGH_OFFSET, 32'hDA);
    acc(0, RX_HIGH_OFFSET, 0);
    `CHK("rx_high", 32'h1A, rd);
    `CHK("rx_on", 12'h6A5, rx_on);
    $display("test receive done");
    acc(1, 8'h00, 32'h3F);
    acc(0, RX_LOW_OFFSET, 0);
    `CHK("unmapped_wr", 32'h25, rd);
    `CHK("unmapped_on", 12'h6A5, rx_on);
    `CHK("tx_untouched", 32'h0, tx_on);
    lanes <= 4'hE;
    acc(1, RX_HIGH_OFFSET, 32'h3F);
    lanes <= 4'hF;
    acc(0, RX_HIGH_OFFSET, 0);
    `CHK("lane_off", 32'h1A, rd);
    $display("test refuse done");
    acc(1, TX_HIGH_OFFSET, 32'h2D);
    repeat (4) @(posedge core_clk);
    `CHK("oe_pin_low", 6'h00, tx_oe);
    `CHK("tx_on", 6'h2D, tx_on);
    pin <= 1;
    repeat (4) @(posedge core_clk);
    `CHK("oe_pin_high", 6'h2D, tx_oe);
    acc(1, TX_HIGH_OFFSET, 32'h20);
    `CHK("oe_off", 6'h20, tx_oe);
    acc(0, 8'h00, 0);
    `CHK("unmapped", 32'h0, rd);
    $display("test transmit done");
    rst <= 1;
    repeat (2) @(posedge core_clk);
    rst <= 0;
    acc(0, RX_LOW_OFFSET, 0);
    `CHK("rx_low_reset", 32'h0, rd);
    `CHK("rx_on_reset2", 32'h0, rx_on);
    `CHK("tx_on_reset", 32'h0, tx_on);
    `CHK("oe_reset2", 32'h0, tx_oe);
    $display("test mid reset done");
    test_done();
  end
endmodule : line_enable_regs_tb
